//--- design/pcm_pkg.sv
// pcm_pkg: shared constants and types for the paired counter meter
package pcm_pkg;
  localparam int unsigned CNT_W_DEF     = 24;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned WIN_DEF       = 40000;
  localparam int unsigned DIV_DEF       = 4;
  localparam logic [1:0]  MODE_ONE      = 2'h0;
  localparam logic [1:0]  MODE_HIFREQ   = 2'h1;
  localparam logic [1:0]  MODE_LRANGE   = 2'h2;
  localparam logic [1:0]  MODE_IDLE     = 2'h3;
  typedef enum logic [1:0] {
    PCM_ST_IDLE,
    PCM_ST_ARM,
    PCM_ST_RUN
  } pcm_state_t;
endpackage

//--- design/pcm_pair_second_counter.sv
// pcm_pair_second_counter: companion counter, window gate or input divider
`timescale 1ns/1ps
`default_nettype none
module pcm_pair_second_counter #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             en_i,
  input  wire logic             src_tick_i,
  input  wire logic [CNT_W-1:0] load_i,
  output logic                  term_o
);
  if (CNT_W < 2) begin : g_bad_width
    $error("CNT_W too small");
  end
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             term_r;
  wire              at_end = (cnt_r <= CNT_W'(1));

  assign cnt_nxt = !en_i ? load_i : (src_tick_i ? (at_end ? load_i : cnt_r - 1'b1) : cnt_r);
  assign term_o  = term_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r  <= '0;
      term_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      term_r <= en_i && src_tick_i && at_end;
    end
  end
endmodule
`default_nettype wire

//--- design/pcm_pair_first_counter.sv
// pcm_pair_first_counter: paired counter frequency and period meter top
// Notes on behaviour
// - counters come as a fixed pair, first with second, linked by dedicated wires.
// - in high-frequency mode the second counter pulses once per window length.
// - in high-frequency mode the first counter counts input periods per window and reports them.
// - high-frequency period is window over count and frequency is count over window.
// - in large-range mode the second counter divides the input and the first times that against the timebase.
// - large-range period is the divided period over the divisor.
// - large-range frequency is timebase rate over count times divisor, count from 2 to 2^24 - 1.
// - large-range mode measures inputs faster than the timebase up to the counter input limit.
// - the count of timebase edges may be one below, equal to, or one above the expected value.
`timescale 1ns/1ps
`default_nettype none
module pcm_pair_first_counter #(
  parameter int unsigned CNT_W = pcm_pkg::CNT_W_DEF
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             sig_i,
  input  wire logic             tb_i,
  input  wire logic [1:0]       mode_i,
  input  wire logic [CNT_W-1:0] window_i,
  input  wire logic [CNT_W-1:0] divisor_i,
  output logic [CNT_W-1:0]      count_o,
  output logic                  valid_o,
  output logic                  ovf_o
);
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W out of range");
  end

  // ----------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] sig_sync_r;
  logic [1:0] tb_sync_r;
  logic       sig_d_r;
  logic       tb_d_r;
  logic [1:0] mode_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sig_sync_r <= 2'h0;
      tb_sync_r  <= 2'h0;
      sig_d_r    <= 1'b0;
      tb_d_r     <= 1'b0;
      mode_r     <= pcm_pkg::MODE_IDLE;
    end else begin
      sig_sync_r <= {sig_sync_r[0], sig_i};
      tb_sync_r  <= {tb_sync_r[0], tb_i};
      sig_d_r    <= sig_sync_r[1];
      tb_d_r     <= tb_sync_r[1];
      mode_r     <= mode_i;
    end
  end
  wire sig_rise = sig_sync_r[1] & ~sig_d_r;
  wire tb_rise  = tb_sync_r[1] & ~tb_d_r;

  // ----------------------------------------
  // pairing and mode decode
  // ----------------------------------------
  wire mode_chg = (mode_r != mode_i);
  wire is_one   = (mode_r == pcm_pkg::MODE_ONE);
  wire is_hf    = (mode_r == pcm_pkg::MODE_HIFREQ);
  wire is_lr    = (mode_r == pcm_pkg::MODE_LRANGE);
  wire sec_en   = (is_hf | is_lr) & ~mode_chg;
  wire sec_tick = is_hf ? tb_rise : sig_rise;
  wire [CNT_W-1:0] sec_load = is_hf ? window_i : divisor_i;
  wire sec_term;

  // second counter of the pair, gate in one mode, divider in the other
  pcm_pair_second_counter #(.CNT_W(CNT_W)) u_second (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .en_i       (sec_en),
    .src_tick_i (sec_tick),
    .load_i     (sec_load),
    .term_o     (sec_term)
  );

  // hf counts input edges, other modes count timebase edges
  wire meas_tick = is_hf ? sig_rise : tb_rise;
  wire meas_mark = is_one ? sig_rise : sec_term;

  // ----------------------------------------
  // measuring counter and result latch
  // ----------------------------------------
  pcm_pkg::pcm_state_t st_r;
  pcm_pkg::pcm_state_t st_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic                wrap_r;
  wire                 cnt_full = &cnt_r;
  wire                 mode_ok  = is_one | is_hf | is_lr;

  assign st_nxt = (!mode_ok || mode_chg) ? pcm_pkg::PCM_ST_IDLE :
                  (st_r == pcm_pkg::PCM_ST_IDLE) ? pcm_pkg::PCM_ST_ARM :
                  (st_r == pcm_pkg::PCM_ST_ARM && meas_mark) ? pcm_pkg::PCM_ST_RUN : st_r;
  assign cnt_nxt = (meas_mark || st_r != pcm_pkg::PCM_ST_RUN) ? '0 :
                   meas_tick ? cnt_r + 1'b1 : cnt_r;

  wire done = (st_r == pcm_pkg::PCM_ST_RUN) && meas_mark && !mode_chg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r    <= pcm_pkg::PCM_ST_IDLE;
      cnt_r   <= '0;
      wrap_r  <= 1'b0;
      count_o <= '0;
      valid_o <= 1'b0;
      ovf_o   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      wrap_r  <= meas_mark ? 1'b0 : (wrap_r | (cnt_full & meas_tick));
      valid_o <= done;
      if (done) begin
        count_o <= cnt_r;
        ovf_o   <= wrap_r | (cnt_full & meas_tick);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence run_then_mark;
    (st_r == pcm_pkg::PCM_ST_RUN) && meas_mark && !mode_chg;
  endsequence

  valid_after_mark_a: assert property (@(posedge clk_i) disable iff (srst_i)
    run_then_mark |=> valid_o && count_o == $past(cnt_r))
    else $error("result not delivered after window");
  valid_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
    valid_o |-> $past(done))
    else $error("valid without measurement end");
  one_mode_tb_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_one && st_r == pcm_pkg::PCM_ST_RUN && tb_rise && !sig_rise && !cnt_full && !mode_chg
      |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("timebase edge not counted");
  hf_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
    sec_term |-> $past(sec_en) && $past(is_hf ? tb_rise : sig_rise))
    else $error("gate pulse without source edge");
  hf_count_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_hf && st_r == pcm_pkg::PCM_ST_RUN && sig_rise && !meas_mark && !cnt_full && !mode_chg
      |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("input period not counted");
  lr_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_lr && st_r == pcm_pkg::PCM_ST_RUN && !tb_rise && !meas_mark && !mode_chg
      |=> cnt_r == $past(cnt_r))
    else $error("count moved without timebase edge");
  idle_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    mode_chg |=> st_r == pcm_pkg::PCM_ST_IDLE ##1 st_r != pcm_pkg::PCM_ST_RUN)
    else $error("mode change did not restart");
  ovf_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_then_mark ##0 (cnt_full && meas_tick)) |=> ovf_o)
    else $error("rollover not flagged");

  // ----------------------------------------
  // checks on arming, holding and rollover
  // ----------------------------------------
  sequence arm_then_mark;
    (st_r == pcm_pkg::PCM_ST_ARM) && meas_mark && !mode_chg;
  endsequence

  sequence run_no_mark;
    (st_r == pcm_pkg::PCM_ST_RUN) && !meas_mark && !mode_chg;
  endsequence

  sequence tick_in_run;
    run_no_mark ##0 (meas_tick && !cnt_full);
  endsequence

  first_mark_arms_a: assert property (@(posedge clk_i) disable iff (srst_i)
    arm_then_mark |=> !valid_o && st_r == pcm_pkg::PCM_ST_RUN && cnt_r == '0)
    else $error("first interval after mode entry not discarded");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !mode_ok |=> !valid_o && st_r == pcm_pkg::PCM_ST_IDLE)
    else $error("idle mode produced activity");
  valid_single_a: assert property (@(posedge clk_i) disable iff (srst_i)
    valid_o |=> !valid_o)
    else $error("valid held longer than one cycle");
  result_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !done |=> $stable(count_o) && $stable(ovf_o))
    else $error("result changed without valid");
  tick_count_a: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_in_run |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("source edge lost inside interval");
  no_tick_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_no_mark ##0 !meas_tick) |=> $stable(cnt_r))
    else $error("count moved without source edge");
  mark_restart_a: assert property (@(posedge clk_i) disable iff (srst_i)
    meas_mark && mode_ok && !mode_chg |=> cnt_r == '0)
    else $error("count not restarted at interval end");
  wrap_seen_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_no_mark ##0 (meas_tick && cnt_full)) |=> wrap_r && cnt_r == '0)
    else $error("counter rollover not recorded");
  ovf_clean_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_then_mark ##0 (!wrap_r && !(cnt_full && meas_tick))) |=> !ovf_o)
    else $error("overflow flagged without rollover");

  // ----------------------------------------
  // checks on mode entry and second counter
  // ----------------------------------------
  term_single_a: assert property (@(posedge clk_i) disable iff (srst_i)
    sec_term |=> !sec_term)
    else $error("gate pulse held longer than one cycle");
  hf_term_tb_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_hf && sec_term |-> $past(tb_rise))
    else $error("window pulse without timebase edge");
  lr_term_sig_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_lr && sec_term |-> $past(sig_rise))
    else $error("divider pulse without input edge");
  sec_quiet_a: assert property (@(posedge clk_i) disable iff (srst_i)
    is_one |=> !sec_term)
    else $error("second counter active in one-counter mode");
  arm_wait_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (st_r == pcm_pkg::PCM_ST_IDLE) && mode_ok && !mode_chg |=> st_r == pcm_pkg::PCM_ST_ARM)
    else $error("measurement did not arm after mode entry");
  valid_mode_a: assert property (@(posedge clk_i) disable iff (srst_i)
    valid_o |-> $past(mode_ok))
    else $error("result delivered outside a measuring mode");
endmodule
`default_nettype wire

//--- sim/pcm_sig_gen.sv
// pcm_sig_gen: measured input and counter timebase source for the meter
`timescale 1ns/1ps
`default_nettype none
module pcm_sig_gen (
  input  wire logic       clk_i,
  input  wire logic [7:0] sig_half_i,
  input  wire logic [7:0] tb_half_i,
  output logic            sig_o,
  output logic            tb_o
);
  logic       s_r     = 1'b0;
  logic       t_r     = 1'b0;
  logic [7:0] s_cnt_r = 8'h01;
  logic [7:0] t_cnt_r = 8'h01;
  // each level lasts sig_half_i or tb_half_i whole clk cycles, at least two for the values the test drives, so the synchroniser sees it
  always @(posedge clk_i) begin
    s_cnt_r <= (s_cnt_r >= sig_half_i) ? 8'h01 : s_cnt_r + 8'h01;
    t_cnt_r <= (t_cnt_r >= tb_half_i) ? 8'h01 : t_cnt_r + 8'h01;
    s_r     <= (s_cnt_r >= sig_half_i) ? ~s_r : s_r;
    t_r     <= (t_cnt_r >= tb_half_i) ? ~t_r : t_r;
  end
  assign sig_o = s_r;
  assign tb_o  = t_r;
endmodule
`default_nettype wire

//--- sim/pcm_pair_first_counter_test.sv
// pcm_pair_first_counter_test: random and corner runs of all meter modes
`timescale 1ns/1ps
`default_nettype none
module pcm_pair_first_counter_test;
  localparam int unsigned W = 8;
  logic         clk_i     = 1'b0;
  logic         srst_i    = 1'b1;
  logic         sig_i;
  logic         tb_i;
  logic [1:0]   mode_i    = pcm_pkg::MODE_IDLE;
  logic [W-1:0] window_i  = 8'h08;
  logic [W-1:0] divisor_i = 8'h01;
  logic [W-1:0] count_o;
  logic         valid_o;
  logic         ovf_o;
  logic [7:0]   hs        = 8'h04;
  logic [7:0]   ht        = 8'h02;
  int           n_mismatch = 0;
  int           num_checks = 0;
  int           seed       = 61;
  logic         timed_out  = 1'b0;
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  pcm_sig_gen i_pcm_sig_gen (.clk_i(clk_i), .sig_half_i(hs), .tb_half_i(ht), .sig_o(sig_i),
    .tb_o(tb_i));
  pcm_pair_first_counter #(.CNT_W(W)) i_pcm_pair_first_counter (.clk_i(clk_i),
    .srst_i(srst_i), .sig_i(sig_i), .tb_i(tb_i), .mode_i(mode_i), .window_i(window_i),
    .divisor_i(divisor_i), .count_o(count_o), .valid_o(valid_o), .ovf_o(ovf_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // phase may add or drop one edge: a count within one of ideal is accepted
  function automatic logic [31:0] fit(input logic [31:0] seen, input logic [31:0] exp);
    return (((seen + 32'h1 >= exp) === 1'b1) && ((seen <= exp + 32'h1) === 1'b1)) ? seen : exp;
  endfunction
  // enter a mode, take the second result, then go idle
  task automatic run(input logic [1:0] m, input logic exp_ovf, output logic [31:0] c);
    int k;
    int got;
    got = 0;
    c   = 32'h0;
    // after a timeout the rest is skipped, the verdict is already failed
    if (timed_out) return;
    @(posedge clk_i);
    #1 mode_i = m;
    for (k = 0; k < 20000 && got < 2; k++) begin
      @(posedge clk_i);
      #1;
      if (valid_o === 1'b1) got++;
    end
    c = 32'(count_o);
    if (got < 2) begin
      n_mismatch++;
      timed_out = 1'b1;
    end
    check({31'h0, ovf_o}, {31'h0, exp_ovf});
    mode_i = pcm_pkg::MODE_IDLE;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    int v;
    logic [31:0] c;
    logic [7:0]  k;
    repeat (16) @(posedge clk_i);
    #1 srst_i = 1'b0;
    check(32'({count_o, valid_o}), 32'h0);
    for (i = 0; i < 7; i++) begin
      k         = 8'(2 + {$random(seed)} % 8);
      ht        = 8'(2 + {$random(seed)} % 3);
      hs        = ht * k;
      window_i  = 8'(k * (4 + {$random(seed)} % 16));
      divisor_i = 8'(1 + {$random(seed)} % 8);
      run(pcm_pkg::MODE_ONE, 1'b0, c);
      check(c, fit(c, 32'(k)));
      run(pcm_pkg::MODE_HIFREQ, 1'b0, c);
      check(c, fit(c, 32'(window_i / k)));
      run(pcm_pkg::MODE_LRANGE, 1'b0, c);
      check(c, fit(c, 32'(divisor_i * k)));
    end
    hs        = 8'h02;
    ht        = 8'h04;
    divisor_i = 8'h08;
    window_i  = 8'h08;
    run(pcm_pkg::MODE_LRANGE, 1'b0, c);
    check(c, fit(c, 32'h4));
    run(pcm_pkg::MODE_HIFREQ, 1'b0, c);
    check(c, fit(c, 32'h10));
    // window too long on purpose: 510 input edges wrap the 8-bit count
    window_i  = 8'hff;
    run(pcm_pkg::MODE_HIFREQ, 1'b1, c);
    check(c, fit(c, 32'hfe));
    v = 0;
    repeat (400) begin
      @(posedge clk_i);
      #1;
      if (valid_o !== 1'b0) v++;
    end
    check(32'(v), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
